// ### hdl/css_context_switch_sequencer.v
// Purpose: context save, context load and block move sequencer
// Assumes: memory on a classic Wishbone master port, same clock
// Notes:   registers reached over a classic Wishbone slave
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "css_defines.vh"
module css_context_switch_sequencer (
  input  wire        clk_i,       // processor clock
  input  wire        rst_i,       // synchronous reset, high
  input  wire        ce_i,        // clock enable
  input  wire        wb_cyc_i,    // slave cycle
  input  wire        wb_stb_i,    // slave strobe
  input  wire        wb_we_i,     // slave write
  input  wire [31:0] wb_adr_i,    // slave byte address
  input  wire [3:0]  wb_sel_i,    // slave byte enables
  input  wire [31:0] wb_dat_i,    // slave write data
  output reg  [31:0] wb_dat_o,    // slave read data
  output reg         wb_ack_o,    // slave acknowledge
  output reg         mem_cyc_o,   // memory cycle
  output reg         mem_stb_o,   // memory strobe
  output reg         mem_we_o,    // memory write
  output reg  [31:0] mem_adr_o,   // memory address
  output reg  [3:0]  mem_sel_o,   // memory byte enables
  output reg  [31:0] mem_dat_o,   // memory write data
  input  wire [31:0] mem_dat_i,   // memory read data
  input  wire        mem_ack_i,   // memory acknowledge
  input  wire        mem_err_i,   // memory fault
  output reg         busy_o,      // sequence running
  output reg         done_o,      // sequence finished pulse
  output reg         flush_o,     // cache flush pulse
  output reg         exc_o,       // fault pulse
  output reg  [1:0]  exc_class_o, // exception class
  output reg         exc_new_o    // fault belongs to new block
);
  localparam [18:0] ST_IDLE = 19'h00001;
  localparam [18:0] ST_SPC  = 19'h00002;
  localparam [18:0] ST_SRN  = 19'h00004;
  localparam [18:0] ST_SPSW = 19'h00008;
  localparam [18:0] ST_SSP  = 19'h00010;
  localparam [18:0] ST_SAP  = 19'h00020;
  localparam [18:0] ST_SFP  = 19'h00040;
  localparam [18:0] ST_SGPR = 19'h00080;
  localparam [18:0] ST_LSET = 19'h00100;
  localparam [18:0] ST_LPSW = 19'h00200;
  localparam [18:0] ST_LPC  = 19'h00400;
  localparam [18:0] ST_LSP  = 19'h00800;
  localparam [18:0] ST_LFIN = 19'h01000;
  localparam [18:0] ST_MSET = 19'h02000;
  localparam [18:0] ST_MSZ  = 19'h04000;
  localparam [18:0] ST_MDST = 19'h08000;
  localparam [18:0] ST_MRD  = 19'h10000;
  localparam [18:0] ST_MWR  = 19'h20000;
  localparam [18:0] ST_END  = 19'h40000;

  reg [31:0] gpr [0:15];  // r0-r8 and dedicated registers
  reg [31:0] new_ptr;     // new control block pointer
  reg [31:0] tmp;         // word in flight during a copy
  reg [18:0] state;       // sequencer state
  reg [3:0]  cnt;         // general register index
  reg        go_save;     // run context_save_seq
  reg        go_load;     // run context_load_seq
  reg        go_move;     // run block_move_seq
  reg [1:0]  mode;        // invoking sequence
  reg        fault;       // sticky fault flag
  reg [1:0]  phase;       // sub-sequence running
  integer    i;

  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [4:0]  wb_ix  = wb_adr_i[6:2];
  wire        wb_hi  = |wb_adr_i[31:7];
  wire [31:0] control_block_pointer   = gpr[`CSS_IX_CONTROL_BLOCK_POINTER];
  wire [31:0] processor_status_word    = gpr[`CSS_IX_PSW];
  wire [31:0] r0     = gpr[0];
  wire [31:0] r2m1   = gpr[2] - 32'h00000001;
  // after a save only the selected later sub-sequences may run
  wire [18:0] next_sub = go_load ? ST_LSET : (go_move ? ST_MSET : ST_END);

  // forces a word-aligned address
  function [31:0] wadr;
    input [31:0] a;
    begin
      wadr = {a[31:2], 2'b00};
    end
  endfunction

  // merges write data under byte enables
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b])
          merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // starts one full-word memory access
  task issue;
    input        we;
    input [31:0] a;
    input [31:0] d;
    begin
      mem_cyc_o <= 1'b1;
      mem_stb_o <= 1'b1;
      mem_we_o  <= we;
      mem_adr_o <= wadr(a);
      mem_sel_o <= 4'hF;
      mem_dat_o <= d;
    end
  endtask

  // register read multiplexer
  reg [31:0] rd_word;
  always @* begin
    rd_word = `CSS_RST_WORD;
    if (!wb_hi) begin
      case (wb_ix)
        `CSS_IX_CTRL: rd_word = {26'h0, mode, 1'b0, go_move, go_load, go_save};
        `CSS_IX_STAT: rd_word = {25'h0, phase, exc_new_o, exc_class_o, fault, busy_o};
        `CSS_IX_NEWP: rd_word = new_ptr;
        default: begin
          if (!wb_ix[4])
            rd_word = gpr[wb_ix[3:0]];
        end
      endcase
    end
  end

  // bus slave, sequencer and memory master
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < 16; i = i + 1)
        gpr[i] <= `CSS_RST_WORD;
      new_ptr     <= `CSS_RST_WORD;
      tmp         <= `CSS_RST_WORD;
      state       <= ST_IDLE;
      cnt         <= 4'h0;
      go_save     <= 1'b0;
      go_load     <= 1'b0;
      go_move     <= 1'b0;
      mode        <= `CSS_MODE_INSTR;
      fault       <= 1'b0;
      phase       <= `CSS_PH_NONE;
      wb_dat_o    <= `CSS_RST_WORD;
      wb_ack_o    <= 1'b0;
      mem_cyc_o   <= 1'b0;
      mem_stb_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_adr_o   <= `CSS_RST_WORD;
      mem_sel_o   <= 4'h0;
      mem_dat_o   <= `CSS_RST_WORD;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      flush_o     <= 1'b0;
      exc_o       <= 1'b0;
      exc_class_o <= `CSS_EXC_NONE;
      exc_new_o   <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      done_o   <= 1'b0;
      flush_o  <= 1'b0;
      exc_o    <= 1'b0;
      // slave access, registers frozen while a sequence runs
      if (wb_req) begin
        wb_dat_o <= rd_word;
        if (wb_we_i && !busy_o && !wb_hi) begin
          if (wb_ix == `CSS_IX_NEWP)
            new_ptr <= merge(new_ptr, wb_dat_i, wb_sel_i);
          else if (wb_ix == `CSS_IX_CTRL && wb_sel_i[0]) begin
            go_save <= wb_dat_i[`CSS_CTL_SAVE];
            go_load <= wb_dat_i[`CSS_CTL_LOAD];
            go_move <= wb_dat_i[`CSS_CTL_MOVE];
            mode    <= wb_dat_i[`CSS_CTL_MODE];
            if (|wb_dat_i[2:0]) begin
              fault       <= 1'b0;
              exc_class_o <= `CSS_EXC_NONE;
              exc_new_o   <= 1'b0;
              busy_o      <= 1'b1;
              state <= wb_dat_i[0] ? ST_SPC : (wb_dat_i[1] ? ST_LSET : ST_MSET);
            end
          end else if (!wb_ix[4])
            gpr[wb_ix[3:0]] <= merge(gpr[wb_ix[3:0]], wb_dat_i, wb_sel_i);
        end
      end
      if (mem_cyc_o && (mem_ack_i || mem_err_i)) begin
        mem_cyc_o <= 1'b0;
        mem_stb_o <= 1'b0;
      end
      // a fault ends the run; the invoker maps it to a class
      if (mem_cyc_o && mem_err_i) begin
        fault     <= 1'b1;
        exc_o     <= 1'b1;
        busy_o    <= 1'b0;
        state     <= ST_IDLE;
        exc_new_o <= (phase != `CSS_PH_SAVE);
        case (mode)
          `CSS_MODE_FULL: exc_class_o <= `CSS_EXC_PROC;
          `CSS_MODE_PRST: exc_class_o <= `CSS_EXC_RST;
          default:        exc_class_o <= `CSS_EXC_NONE;
        endcase
      end else begin
        case (state)
          ST_IDLE: begin
            phase <= `CSS_PH_NONE;
          end
          // context_save_seq
          ST_SPC: begin
            phase <= `CSS_PH_SAVE;
            if (!mem_cyc_o)
              issue(1'b1, control_block_pointer + `CSS_OFF_PC, gpr[`CSS_IX_PC]);
            else if (mem_ack_i)
              state <= ST_SRN;
          end
          ST_SRN: begin
            if (!mem_cyc_o)
              issue(1'b0, new_ptr, `CSS_RST_WORD);
            else if (mem_ack_i) begin
              gpr[`CSS_IX_PSW][`CSS_PSW_R] <= mem_dat_i[`CSS_PSW_R];
              state <= ST_SPSW;
            end
          end
          ST_SPSW: begin
            if (!mem_cyc_o)
              issue(1'b1, control_block_pointer, processor_status_word);
            else if (mem_ack_i)
              state <= ST_SSP;
          end
          ST_SSP: begin
            if (!mem_cyc_o)
              issue(1'b1, control_block_pointer + `CSS_OFF_SP, gpr[`CSS_IX_SP]);
            else if (mem_ack_i)
              state <= processor_status_word[`CSS_PSW_R] ? ST_SAP : next_sub;
          end
          ST_SAP: begin
            if (!mem_cyc_o)
              issue(1'b1, control_block_pointer + `CSS_OFF_AP, gpr[`CSS_IX_AP]);
            else if (mem_ack_i)
              state <= ST_SFP;
          end
          ST_SFP: begin
            cnt <= 4'h0;
            if (!mem_cyc_o)
              issue(1'b1, control_block_pointer + `CSS_OFF_FP, gpr[`CSS_IX_FP]);
            else if (mem_ack_i)
              state <= ST_SGPR;
          end
          ST_SGPR: begin
            if (!mem_cyc_o)
              issue(1'b1, control_block_pointer + `CSS_OFF_R0 + {26'h0, cnt, 2'b00}, gpr[cnt]);
            else if (mem_ack_i) begin
              cnt <= cnt + 4'h1;
              if (cnt == `CSS_NUM_GPR) begin
                gpr[`CSS_IX_FP] <= control_block_pointer + `CSS_OFF_FPSET;
                state <= next_sub;
              end
            end
          end
          // context_load_seq
          ST_LSET: begin
            phase <= `CSS_PH_LOAD;
            gpr[`CSS_IX_CONTROL_BLOCK_POINTER] <= new_ptr;
            state <= ST_LPSW;
          end
          ST_LPSW: begin
            if (!mem_cyc_o)
              issue(1'b0, control_block_pointer, `CSS_RST_WORD);
            else if (mem_ack_i) begin
              gpr[`CSS_IX_PSW] <= mem_dat_i & ~(32'h1 << `CSS_PSW_TM);
              state <= ST_LPC;
            end
          end
          ST_LPC: begin
            if (!mem_cyc_o)
              issue(1'b0, control_block_pointer + `CSS_OFF_PC, `CSS_RST_WORD);
            else if (mem_ack_i) begin
              gpr[`CSS_IX_PC] <= mem_dat_i;
              state <= ST_LSP;
            end
          end
          ST_LSP: begin
            if (!mem_cyc_o)
              issue(1'b0, control_block_pointer + `CSS_OFF_SP, `CSS_RST_WORD);
            else if (mem_ack_i) begin
              gpr[`CSS_IX_SP] <= mem_dat_i;
              state <= ST_LFIN;
            end
          end
          ST_LFIN: begin
            if (processor_status_word[`CSS_PSW_I]) begin
              gpr[`CSS_IX_PSW][`CSS_PSW_I] <= 1'b0;
              gpr[`CSS_IX_CONTROL_BLOCK_POINTER] <= control_block_pointer + `CSS_OFF_INIT;
            end
            flush_o <= ~processor_status_word[`CSS_PSW_CFD];
            state   <= go_move ? ST_MSET : ST_END;
          end
          // block_move_seq
          ST_MSET: begin
            phase <= `CSS_PH_MOVE;
            if (processor_status_word[`CSS_PSW_R]) begin
              gpr[0] <= control_block_pointer + `CSS_OFF_BLK;
              state  <= ST_MSZ;
            end else
              state <= ST_END;
          end
          ST_MSZ: begin
            if (!mem_cyc_o)
              issue(1'b0, r0, `CSS_RST_WORD);
            else if (mem_ack_i) begin
              gpr[2] <= mem_dat_i;
              if (mem_dat_i == 32'h0) begin
                gpr[0] <= r0 + `CSS_OFF_STEP + `CSS_OFF_STEP;
                state  <= ST_END;
              end else begin
                gpr[0] <= r0 + `CSS_OFF_STEP;
                state  <= ST_MDST;
              end
            end
          end
          ST_MDST: begin
            if (!mem_cyc_o)
              issue(1'b0, r0, `CSS_RST_WORD);
            else if (mem_ack_i) begin
              gpr[1] <= mem_dat_i;
              gpr[0] <= r0 + `CSS_OFF_STEP;
              state  <= ST_MRD;
            end
          end
          // word_block_copy from r0 to r1, r2 words
          ST_MRD: begin
            if (!mem_cyc_o)
              issue(1'b0, r0, `CSS_RST_WORD);
            else if (mem_ack_i) begin
              tmp   <= mem_dat_i;
              state <= ST_MWR;
            end
          end
          ST_MWR: begin
            if (!mem_cyc_o)
              issue(1'b1, gpr[1], tmp);
            else if (mem_ack_i) begin
              gpr[0] <= r0 + `CSS_OFF_STEP;
              gpr[1] <= gpr[1] + `CSS_OFF_STEP;
              gpr[2] <= r2m1;
              state  <= (r2m1 == 32'h0) ? ST_MSZ : ST_MRD;
            end
          end
          ST_END: begin
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state  <= ST_IDLE;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // css_context_switch_sequencer

// ### hdl/css_defines.vh
// Purpose: shared constants of the context switch sequencer
// Assumes: 32-bit words, word-aligned control block
// Notes:   definitions only
`ifndef CSS_DEFINES_VH
`define CSS_DEFINES_VH
// register index, byte address is four times the index
`define CSS_IX_FP    4'h9
`define CSS_IX_AP    4'hA
`define CSS_IX_PSW   4'hB
`define CSS_IX_SP    4'hC
`define CSS_IX_CONTROL_BLOCK_POINTER  4'hD
`define CSS_IX_PC    4'hF
`define CSS_IX_CTRL  5'h10
`define CSS_IX_STAT  5'h11
`define CSS_IX_NEWP  5'h12
// control register fields
`define CSS_CTL_SAVE 0
`define CSS_CTL_LOAD 1
`define CSS_CTL_MOVE 2
`define CSS_CTL_MODE 5:4
// invoking sequence codes
`define CSS_MODE_INSTR 2'h0
`define CSS_MODE_FULL  2'h1
`define CSS_MODE_PRST  2'h2
// exception class codes
`define CSS_EXC_NONE 2'h0
`define CSS_EXC_PROC 2'h2
`define CSS_EXC_RST  2'h3
// sub-sequence codes
`define CSS_PH_NONE 2'h0
`define CSS_PH_SAVE 2'h1
`define CSS_PH_LOAD 2'h2
`define CSS_PH_MOVE 2'h3
// status word bit positions
`define CSS_PSW_TM  2
`define CSS_PSW_I   7
`define CSS_PSW_R   8
`define CSS_PSW_CFD 17
// control block offsets in bytes
`define CSS_OFF_PC    32'h00000004
`define CSS_OFF_SP    32'h00000008
`define CSS_OFF_INIT  32'h0000000C
`define CSS_OFF_AP    32'h00000014
`define CSS_OFF_FP    32'h00000018
`define CSS_OFF_R0    32'h0000001C
`define CSS_OFF_FPSET 32'h00000034
`define CSS_OFF_BLK   32'h00000040
`define CSS_OFF_STEP  32'h00000004
// index of the last general register saved
`define CSS_NUM_GPR   4'h8
`define CSS_RST_WORD  32'h00000000
`endif

// ### verif/css_checker.sv
// Purpose: port assertions of the context switch sequencer
// Assumes: one clock, rst_i synchronous and high
// Notes:   bound to the top module below
`timescale 1ns/100ps
module css_checker (
  input wire        clk_i, rst_i,               // clock and reset
  input wire        mem_cyc_o, mem_stb_o,       // memory request
  input wire        mem_we_o, mem_ack_i,        // direction, answer
  input wire        mem_err_i,                  // memory fault
  input wire [31:0] mem_adr_o,                  // memory address
  input wire [3:0]  mem_sel_o,                  // byte enables
  input wire        busy_o, done_o, flush_o, exc_o // busy level, status pulses
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // an access ending, and one ending in a fault
  sequence s_end; mem_stb_o && (mem_ack_i || mem_err_i); endsequence
  sequence s_err; mem_stb_o && mem_err_i; endsequence
  property p_word; mem_stb_o |-> mem_sel_o == 4'hF && mem_adr_o[1:0] == 2'h0; endproperty
  a_word: assert property (p_word) else $error("access not full word");
  property p_hold;
    mem_stb_o && !mem_ack_i && !mem_err_i |=> mem_stb_o && $stable(mem_adr_o) && $stable(mem_we_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed early");
  property p_gap; s_end |=> !mem_cyc_o; endproperty
  a_gap: assert property (p_gap) else $error("no idle after access");
  property p_stop; s_err |-> ##[1:2] exc_o; endproperty
  a_stop: assert property (p_stop) else $error("fault not reported");
  property p_quiet; s_err |=> !mem_stb_o [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("access after fault");
  property p_exc; exc_o |-> ##[0:1] !busy_o; endproperty
  a_exc: assert property (p_exc) else $error("busy after fault");
  property p_done; done_o |-> !mem_cyc_o && !exc_o; endproperty
  a_done: assert property (p_done) else $error("done with access open");
  property p_flush; flush_o |=> !flush_o; endproperty
  a_flush: assert property (p_flush) else $error("flush not a pulse");
endmodule // css_checker
bind css_context_switch_sequencer css_checker css_checker_inst (.clk_i, .rst_i,
  .mem_cyc_o, .mem_stb_o, .mem_we_o, .mem_ack_i, .mem_err_i, .mem_adr_o,
  .mem_sel_o, .busy_o, .done_o, .flush_o, .exc_o);

// ### verif/css_mem_model.sv
// Purpose: system memory model behind a classic Wishbone slave port
// Assumes: 64 words, word picked by adr[7:2]
// Notes:   dly_i wait states; access number err_at_i answers with a fault
`timescale 1ns/100ps
module css_mem_model (
  input  wire        clk_i,    // clock
  input  wire        rst_i,    // sync reset, clears access count
  input  wire        cyc_i,    // cycle
  input  wire        stb_i,    // strobe
  input  wire        we_i,     // write
  input  wire [31:0] adr_i,    // byte address
  input  wire [31:0] dat_i,    // write data
  input  wire [3:0]  dly_i,    // wait states
  input  wire [7:0]  err_at_i, // faulting access number
  output reg  [31:0] dat_o,    // read data
  output reg         ack_o,    // acknowledge
  output reg         err_o     // fault
);
  reg [31:0] m [0:63];
  reg [3:0]  cnt;
  reg [7:0]  n;
  initial dat_o = 32'h00000000;
  // answer after the waits; data lines toggle whenever no read is answered
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    dat_o <= ~dat_o;
    if (rst_i) begin
      cnt <= 4'h0;
      n   <= 8'h00;
    end else if (cyc_i && stb_i && !ack_o && !err_o) begin
      if (cnt != dly_i)
        cnt <= cnt + 4'h1;
      else begin
        cnt <= 4'h0;
        n   <= n + 8'h01;
        if (n == err_at_i)
          err_o <= 1'b1;
        else begin
          ack_o <= 1'b1;
          if (we_i)
            m[adr_i[7:2]] <= dat_i;
          else
            dat_o <= m[adr_i[7:2]];
        end
      end
    end
  end
endmodule // css_mem_model

// ### verif/test_css_context_switch_sequencer.sv
// Purpose: register-level tests of the context switch sequencer
// Assumes: memory model answers on the far side
// Notes:   save, load and move paths plus faults in each invoking mode
`timescale 1ns/100ps
module test_css_context_switch_sequencer;
  reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [31:0] wb_adr_i, wb_dat_i, q;
  reg  [3:0]  dly, wb_sel_i;
  reg  [7:0]  err_at;
  wire [31:0] wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i;
  wire [3:0]  mem_sel_o;
  wire [1:0]  exc_class_o;
  wire        wb_ack_o, mem_cyc_o, mem_stb_o, mem_we_o, mem_ack_i, mem_err_i;
  wire        busy_o, done_o, flush_o, exc_o, exc_new_o;
  integer     mismatches, cmp_count, nfl, i;
  css_context_switch_sequencer css_context_switch_sequencer_inst (.clk_i, .rst_i,
    .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_cyc_o, .mem_stb_o, .mem_we_o, .mem_adr_o,
    .mem_sel_o, .mem_dat_o, .mem_dat_i, .mem_ack_i, .mem_err_i, .busy_o, .done_o,
    .flush_o, .exc_o, .exc_class_o, .exc_new_o);
  css_mem_model css_mem_model_inst (.clk_i, .rst_i, .cyc_i(mem_cyc_o),
    .stb_i(mem_stb_o), .we_i(mem_we_o), .adr_i(mem_adr_o), .dat_i(mem_dat_o),
    .dly_i(dly), .err_at_i(err_at), .dat_o(mem_dat_i), .ack_o(mem_ack_i),
    .err_o(mem_err_i));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // count cache flush pulses
  always @(posedge clk_i) if (flush_o === 1'b1) nfl <= nfl + 1;
  function [31:0] mm(input integer k);
    mm = css_mem_model_inst.m[k];
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one classic Wishbone cycle; read data lands in q
  task wb(input w, input [31:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      t = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && t < 20) begin
        @(posedge clk_i);
        t = t + 1;
      end
      if (t == 20) mismatches = mismatches + 1;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task rchk(input [31:0] a, input [31:0] exp);
    begin
      wb(1'b0, a, 32'h00000000);
      chk(q, exp);
    end
  endtask
  // start sequences and wait for the end or a fault
  task run(input [31:0] ctl);
    integer t;
    begin
      wb(1'b1, 32'h00000040, ctl);
      t = 0;
      while (done_o !== 1'b1 && exc_o !== 1'b1 && t < 3000) begin
        @(posedge clk_i);
        t = t + 1;
      end
      if (t == 3000) mismatches = mismatches + 1;
    end
  endtask
  task do_reset;
    begin
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
    end
  endtask
  // fault at a chosen access, then class, block and status
  task fcase(input [31:0] ctl, input [7:0] at, input [1:0] cls, input nw);
    begin
      do_reset;
      err_at <= at;
      wb(1'b1, 32'h00000034, 32'h00000040);
      wb(1'b1, 32'h00000048, 32'h00000080);
      run(ctl);
      chk({30'h0, exc_class_o}, {30'h0, cls});
      chk({31'h0, exc_new_o}, {31'h0, nw});
      rchk(32'h00000044, {27'h0, nw, cls, 2'h2});
      $display("test fault ctl=%h done", ctl);
    end
  endtask
  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    #400000;
    mismatches = mismatches + 1;
    end_of_test;
  end
  // main sequence
  initial begin
    mismatches = 0;
    cmp_count = 0;
    nfl = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_adr_i = 32'h00000000;
    wb_dat_i = 32'h00000000;
    dly = 4'h0;
    err_at = 8'hFF;
    do_reset;
    for (i = 0; i < 9; i = i + 1) wb(1'b1, 4 * i, 32'h100 + i);
    wb(1'b1, 32'h00000024, 32'h000000F0);
    wb(1'b1, 32'h00000028, 32'h000000A0);
    wb(1'b1, 32'h00000030, 32'h00005000);
    wb(1'b1, 32'h00000034, 32'h00000040);
    wb(1'b1, 32'h0000003C, 32'h00001234);
    wb(1'b1, 32'h00000048, 32'h00000080);
    css_mem_model_inst.m[32] = 32'h00000104;
    css_mem_model_inst.m[33] = 32'h00002004;
    css_mem_model_inst.m[34] = 32'h00003008;
    css_mem_model_inst.m[48] = 32'h00000002;
    css_mem_model_inst.m[49] = 32'h00000020;
    css_mem_model_inst.m[50] = 32'h0000AAAA;
    css_mem_model_inst.m[51] = 32'h00005555;
    css_mem_model_inst.m[52] = 32'h00000000;
    run(32'h00000017);
    chk(mm(17), 32'h00001234);
    chk(mm(16), 32'h00000100);
    chk(mm(18), 32'h00005000);
    chk(mm(21), 32'h000000A0);
    chk(mm(22), 32'h000000F0);
    for (i = 0; i < 9; i = i + 1) chk(mm(23 + i), 32'h100 + i);
    rchk(32'h00000024, 32'h00000074);
    rchk(32'h00000034, 32'h00000080);
    rchk(32'h0000002C, 32'h00000100);
    rchk(32'h0000003C, 32'h00002004);
    rchk(32'h00000030, 32'h00003008);
    chk(nfl, 32'h00000001);
    chk(mm(8), 32'h0000AAAA);
    chk(mm(9), 32'h00005555);
    rchk(32'h00000000, 32'h000000D8);
    rchk(32'h00000008, 32'h00000000);
    $display("test save load move done");
    dly <= 4'h3;
    css_mem_model_inst.m[32] = 32'h00020084;
    run(32'h00000002);
    rchk(32'h0000002C, 32'h00020000);
    rchk(32'h00000034, 32'h0000008C);
    chk(nfl, 32'h00000001);
    $display("test initial context load done");
    css_mem_model_inst.m[32] = 32'h00000100;
    fcase(32'h00000011, 8'h00, 2'h2, 1'b0);
    fcase(32'h00000012, 8'h01, 2'h2, 1'b1);
    fcase(32'h00000026, 8'h02, 2'h3, 1'b1);
    fcase(32'h00000001, 8'h01, 2'h0, 1'b0);
    fcase(32'h00000016, 8'h03, 2'h2, 1'b1);
    end_of_test;
  end
endmodule // test_css_context_switch_sequencer
